// *** hw/single_cycle_core_timing.sv ***
`timescale 1ns/10ps
// Behaviour
// - accumulator clear, complement, swap and rotates take one clock
// - accumulator move with indirect internal memory takes two clocks
// - two-byte move of accumulator to direct byte takes two clocks
// - three-byte direct-to-direct move takes three clocks
// - loading the data pointer from immediate takes three clocks
// - code byte read relative to pointer or counter takes four clocks
// - external data move takes four clocks plus programmed wait states
// - push or pop of a direct byte takes two clocks
// - nibble exchange with indirect memory takes two clocks
// - carry-only boolean one clock; bit-with-carry operations two clocks
// - exclusive-or immediate into direct byte takes three clocks
// - indirect jump to accumulator plus pointer takes three clocks
// - carry or zero relative branches take three clocks, taken or not
// - register decrement and branch takes three clocks
// - direct bit test branches, clearing variant too, take four clocks
// - every compare and branch form takes four clocks
// - long call from interrupt entry takes three clocks, otherwise four
// - timers advance once every core clock
// - one-clock instruction: ale high first half, low second half
// - longer instruction: ale high only first half of first clock
// - no external program fetch; only data moves use the bus
// - wait register holds 0 to 7, resets to zero, adds cycles
module single_cycle_core_timing
    import core_timing_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // instruction issue from the decode stage
    input  wire logic instr_valid,
    input  wire instr_class_t instr_class,
    input  wire logic from_interrupt,
    input  wire logic instr_write,
    output logic instr_ready,
    output logic first_cycle,
    output logic [3:0] instr_cycles,
    // timer advance
    output logic timer_tick,
    // external bus timing
    output logic ale,
    output logic ext_access,
    output logic ext_write,
    output logic code_fetch_n,
    // special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic sfr_write,
    input  wire logic sfr_read,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    seq_state_t state;
    seq_state_t next_state;
    logic [2:0] wait_states;
    logic [3:0] remain;
    logic [3:0] next_remain;
    logic [3:0] lookup_cycles;
    logic lookup_ext;
    logic take;
    logic next_ext;

    // address compare shared by read and write decode
    function automatic logic wait_sel(input logic [7:0] addr);
        wait_sel = (addr == WAIT_ADDR);
    endfunction : wait_sel

    // ------------------------------------------------------------
    // cycle count lookup
    // ------------------------------------------------------------
    // the live register value is used, so a move keeps the count of its start
    cycle_lookup u_lookup (
        .instr_class(instr_class),
        .from_interrupt(from_interrupt),
        .wait_states(wait_states),
        .cycles(lookup_cycles),
        .is_ext(lookup_ext)
    );

    // ------------------------------------------------------------
    // instruction sequencer
    // ------------------------------------------------------------
    // a new instruction is taken in the last cycle of the previous one
    assign take = instr_valid && instr_ready;

    // remaining cycles after the current one
    always_comb begin
        next_remain = remain;
        if (take) begin
            next_remain = lookup_cycles - CYC_ONE;
        end else if (remain != 4'h0) begin
            next_remain = remain - 4'h1;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (instr_ready && !take) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // cycle counter and state
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            remain <= 4'h0;
            state <= ST_IDLE;
        end else begin
            remain <= next_remain;
            state <= next_state;
        end
    end

    // ready marks the last cycle of an instruction, or an idle core
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            instr_ready <= 1'b1;
            first_cycle <= 1'b0;
            instr_cycles <= 4'h0;
        end else begin
            instr_ready <= (next_remain == 4'h0);
            first_cycle <= take;
            if (take) begin
                instr_cycles <= lookup_cycles;
            end
        end
    end

    // ------------------------------------------------------------
    // external data bus
    // ------------------------------------------------------------
    // the bus is busy for every cycle of an external data move
    always_comb begin
        next_ext = ext_access;
        if (take) begin
            next_ext = lookup_ext;
        end else if (instr_ready) begin
            next_ext = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ext_access <= 1'b0;
            ext_write <= 1'b0;
        end else begin
            ext_access <= next_ext;
            if (take) begin
                ext_write <= lookup_ext && instr_write;
            end else if (instr_ready) begin
                ext_write <= 1'b0;
            end
        end
    end

    // program store enable stays inactive: code never comes from outside
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            code_fetch_n <= 1'b1;
        end else begin
            code_fetch_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // timers and address latch enable
    // ------------------------------------------------------------
    // one machine cycle per clock, so the tick is high every cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            timer_tick <= 1'b0;
        end else begin
            timer_tick <= 1'b1;
        end
    end

    ale_gen u_ale (
        .clock(clock),
        .reset(reset),
        .next_first_cycle(take),
        .first_cycle(first_cycle),
        .ale(ale)
    );

    // ------------------------------------------------------------
    // wait-state register
    // ------------------------------------------------------------
    // only the three count bits are stored; the upper bits read zero
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wait_states <= WAIT_RESET;
        end else if (sfr_write && wait_sel(sfr_addr)) begin
            wait_states <= sfr_wdata[WAIT_MSB:WAIT_LSB];
        end
    end

    // registered read data, zero off the map
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sfr_rdata <= SFR_UNMAPPED;
            sfr_hit <= 1'b0;
        end else begin
            sfr_hit <= (sfr_read || sfr_write) && wait_sel(sfr_addr);
            if (sfr_read && wait_sel(sfr_addr)) begin
                sfr_rdata <= {5'h00, wait_states};
            end else begin
                sfr_rdata <= SFR_UNMAPPED;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [2:0] chk_waits;
    logic [3:0] chk_ext_len;

    // wait count captured at the start of each external move
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            chk_waits <= 3'h0;
            chk_ext_len <= 4'h0;
        end else begin
            if (take && lookup_ext) begin
                chk_waits <= wait_states;
            end
            if (take) begin
                chk_ext_len <= 4'h1;
            end else if (ext_access) begin
                chk_ext_len <= chk_ext_len + 4'h1;
            end
        end
    end

    sequence seq_len1;
        instr_ready;
    endsequence

    sequence seq_len2;
        !instr_ready ##1 instr_ready;
    endsequence

    sequence seq_len3;
        !instr_ready [*2] ##1 instr_ready;
    endsequence

    sequence seq_len4;
        !instr_ready [*3] ##1 instr_ready;
    endsequence

    chk_acc_one_cycle: assert property (@(posedge clock) disable iff (reset)
        take && instr_class == CLS_ACC_OP |=> seq_len1)
        else $error("accumulator operation not one cycle");

    chk_two_cycle_moves: assert property (@(posedge clock) disable iff (reset)
        take && (instr_class == CLS_INDIRECT_MOVE || instr_class == CLS_DIRECT_WRITE
            || instr_class == CLS_STACK || instr_class == CLS_NIBBLE_XCHG) |=> seq_len2)
        else $error("two-cycle move has wrong length");

    chk_three_cycle_ops: assert property (@(posedge clock) disable iff (reset)
        take && (instr_class == CLS_DIRECT_COPY || instr_class == CLS_POINTER_LOAD
            || instr_class == CLS_XOR_IMM_DIR || instr_class == CLS_JUMP_INDIRECT
            || instr_class == CLS_REL_BRANCH || instr_class == CLS_DEC_BRANCH) |=> seq_len3)
        else $error("three-cycle instruction has wrong length");

    chk_four_cycle_ops: assert property (@(posedge clock) disable iff (reset)
        take && (instr_class == CLS_CODE_READ || instr_class == CLS_BIT_BRANCH
            || instr_class == CLS_COMPARE_BR) |=> seq_len4)
        else $error("four-cycle instruction has wrong length");

    chk_bool_cycles: assert property (@(posedge clock) disable iff (reset)
        take && instr_class == CLS_BIT_CARRY |=> seq_len2)
        else $error("bit with carry operation not two cycles");

    chk_call_irq_len: assert property (@(posedge clock) disable iff (reset)
        take && instr_class == CLS_LONG_CALL && from_interrupt |=> seq_len3)
        else $error("interrupt entry call not three cycles");

    chk_call_normal_len: assert property (@(posedge clock) disable iff (reset)
        take && instr_class == CLS_LONG_CALL && !from_interrupt |=> seq_len4)
        else $error("long call not four cycles");

    chk_ext_length: assert property (@(posedge clock) disable iff (reset)
        ext_access && instr_ready |-> chk_ext_len == CYC_EXT_BASE + {1'b0, chk_waits})
        else $error("external move length differs from four plus waits");

    chk_ext_sampled: assert property (@(posedge clock) disable iff (reset)
        ext_access && !first_cycle |-> $stable(instr_cycles))
        else $error("external move length changed during the move");

    chk_wait_write: assert property (@(posedge clock) disable iff (reset)
        sfr_write && sfr_addr == WAIT_ADDR |=> wait_states == $past(sfr_wdata[2:0]))
        else $error("wait register did not take the written count");

    chk_timer_every: assert property (@(posedge clock) disable iff (reset)
        !$past(reset) |-> timer_tick)
        else $error("timer tick missing in a cycle");

    chk_no_code_fetch: assert property (@(posedge clock) disable iff (reset)
        code_fetch_n && (!ext_access || instr_cycles >= CYC_EXT_BASE))
        else $error("external bus used outside a data move");

endmodule : single_cycle_core_timing

// *** hw/core_timing_pkg.sv ***
package core_timing_pkg;

    // ------------------------------------------------------------
    // special function register map
    // ------------------------------------------------------------
    localparam logic [7:0] WAIT_ADDR = 8'h9f;     // wait-state register
    localparam logic [2:0] WAIT_RESET = 3'h0;     // wait states after reset
    localparam logic [7:0] SFR_UNMAPPED = 8'h00;  // read value off the map
    localparam int WAIT_LSB = 0;                  // count field position
    localparam int WAIT_MSB = 2;

    // ------------------------------------------------------------
    // cycle counts, one cycle is one core clock
    // ------------------------------------------------------------
    localparam logic [3:0] CYC_ONE = 4'h1;
    localparam logic [3:0] CYC_TWO = 4'h2;
    localparam logic [3:0] CYC_THREE = 4'h3;
    localparam logic [3:0] CYC_FOUR = 4'h4;
    localparam logic [3:0] CYC_EXT_BASE = 4'h4;   // external move, no waits
    localparam logic [3:0] CYC_CALL_IRQ = 4'h3;   // call made by interrupt entry

    // ------------------------------------------------------------
    // instruction timing classes, given by the decode stage
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        CLS_ACC_OP        = 5'h00, // clear, complement, swap, rotates
        CLS_INDIRECT_MOVE = 5'h01, // accumulator to or from indirect memory
        CLS_DIRECT_WRITE  = 5'h02, // accumulator to a direct byte
        CLS_DIRECT_COPY   = 5'h03, // direct byte to direct byte
        CLS_POINTER_LOAD  = 5'h04, // data_pointer_reg from immediate
        CLS_CODE_READ     = 5'h05, // code_byte_read
        CLS_EXT_MOVE      = 5'h06, // external_data_move
        CLS_STACK         = 5'h07, // push or pop of a direct byte
        CLS_NIBBLE_XCHG   = 5'h08, // nibble_exchange
        CLS_CARRY_BOOL    = 5'h09, // carry-only boolean
        CLS_BIT_CARRY     = 5'h0a, // direct bit or inverse with carry
        CLS_XOR_IMM_DIR   = 5'h0b, // exclusive-or immediate into direct
        CLS_JUMP_INDIRECT = 5'h0c, // jump to accumulator plus pointer
        CLS_REL_BRANCH    = 5'h0d, // carry or zero relative branch
        CLS_DEC_BRANCH    = 5'h0e, // decrement_branch_nonzero on register
        CLS_BIT_BRANCH    = 5'h0f, // direct bit tests, bit_test_branch_clear
        CLS_COMPARE_BR    = 5'h10, // compare_branch_not_equal forms
        CLS_LONG_CALL     = 5'h11  // long_subroutine_call
    } instr_class_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } seq_state_t;

endpackage : core_timing_pkg

// *** hw/cycle_lookup.sv ***
`timescale 1ns/10ps
module cycle_lookup
    import core_timing_pkg::*;
(
    // instruction class
    input  wire instr_class_t instr_class,
    input  wire logic from_interrupt,
    // programmed wait states
    input  wire logic [2:0] wait_states,
    // length of the instruction
    output logic [3:0] cycles,
    output logic is_ext
);

    // ------------------------------------------------------------
    // cycle count for each timing class
    // ------------------------------------------------------------
    always_comb begin
        is_ext = 1'b0;
        case (instr_class)
            CLS_ACC_OP:        cycles = CYC_ONE;
            CLS_INDIRECT_MOVE: cycles = CYC_TWO;
            CLS_DIRECT_WRITE:  cycles = CYC_TWO;
            CLS_DIRECT_COPY:   cycles = CYC_THREE;
            CLS_POINTER_LOAD:  cycles = CYC_THREE;
            CLS_CODE_READ:     cycles = CYC_FOUR;
            CLS_EXT_MOVE: begin
                cycles = CYC_EXT_BASE + {1'b0, wait_states};
                is_ext = 1'b1;
            end
            CLS_STACK:         cycles = CYC_TWO;
            CLS_NIBBLE_XCHG:   cycles = CYC_TWO;
            CLS_CARRY_BOOL:    cycles = CYC_ONE;
            CLS_BIT_CARRY:     cycles = CYC_TWO;
            CLS_XOR_IMM_DIR:   cycles = CYC_THREE;
            CLS_JUMP_INDIRECT: cycles = CYC_THREE;
            CLS_REL_BRANCH:    cycles = CYC_THREE;
            CLS_DEC_BRANCH:    cycles = CYC_THREE;
            CLS_BIT_BRANCH:    cycles = CYC_FOUR;
            CLS_COMPARE_BR:    cycles = CYC_FOUR;
            CLS_LONG_CALL:     cycles = from_interrupt ? CYC_CALL_IRQ : CYC_FOUR;
            default:           cycles = CYC_ONE;   // unknown classes act as one cycle
        endcase
    end

endmodule : cycle_lookup

// *** hw/ale_gen.sv ***
`timescale 1ns/10ps
module ale_gen (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // first cycle of an instruction begins at the next edge
    input  wire logic next_first_cycle,
    input  wire logic first_cycle,
    // address latch enable pin
    output logic ale
);

    logic rise_phase;
    logic fall_phase;

    // ------------------------------------------------------------
    // half-cycle pulse from two phase flops
    // ------------------------------------------------------------
    // toggles at the rising edge that opens an instruction
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rise_phase <= 1'b0;
        end else if (next_first_cycle) begin
            rise_phase <= ~rise_phase;
        end
    end

    // follows at the falling edge, ending the high half
    always_ff @(negedge clock or posedge reset) begin
        if (reset) begin
            fall_phase <= 1'b0;
        end else begin
            fall_phase <= rise_phase;
        end
    end

    // high from the rising edge to the falling edge of a first cycle only
    assign ale = rise_phase ^ fall_phase;

    // high half seen exactly in first cycles
    chk_ale_first_half: assert property (@(negedge clock) disable iff (reset)
        ale == first_cycle)
        else $error("ale high half does not match the first cycle");

    // ale is low in the second half of every cycle, seen just before each rising edge
    chk_ale_low_second: assert property (@(posedge clock) disable iff (reset)
        !ale)
        else $error("ale high in the second half of a cycle");

endmodule : ale_gen

// *** sim/ext_ram_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// external data ram, seen through the core's move strobes
// ------------------------------------------------------------
module ext_ram_model (
    // clock
    input wire logic clock,
    // strobes from the core
    input wire logic first_cycle,
    input wire logic ext_access,
    input wire logic ext_write,
    // length and direction of the latest move
    output logic [3:0] moved_len,
    output logic moved_write
);
    // only data moves occupy the bus; a new move restarts the count
    always_ff @(posedge clock) begin
        if (ext_access) begin
            moved_len <= first_cycle ? 4'h1 : moved_len + 4'h1;
            moved_write <= ext_write;
        end
    end
endmodule : ext_ram_model

// *** sim/test_single_cycle_core_timing.sv ***
`timescale 1ns/10ps
module test_single_cycle_core_timing;
    import core_timing_pkg::*;

    // ------------------------------------------------------------
    // signals and bench state
    // ------------------------------------------------------------
    logic clock, reset, instr_valid, from_interrupt, instr_write, instr_ready;
    instr_class_t instr_class;
    logic first_cycle, timer_tick, ale, ext_access, ext_write, code_fetch_n;
    logic [3:0] instr_cycles, moved_len;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic sfr_write, sfr_read, sfr_hit, moved_write;
    int bad_count = 0;
    int comparisons = 0;
    int seed = 14;
    int model_wait = 0;
    int r;
    int len_q[$];

    single_cycle_core_timing u_single_cycle_core_timing (.clock(clock), .reset(reset),
        .instr_valid(instr_valid), .instr_class(instr_class), .from_interrupt(from_interrupt),
        .instr_write(instr_write), .instr_ready(instr_ready), .first_cycle(first_cycle),
        .instr_cycles(instr_cycles), .timer_tick(timer_tick), .ale(ale),
        .ext_access(ext_access), .ext_write(ext_write), .code_fetch_n(code_fetch_n),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write),
        .sfr_read(sfr_read), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit));

    ext_ram_model u_ext_ram_model (.clock(clock), .first_cycle(first_cycle),
        .ext_access(ext_access), .ext_write(ext_write), .moved_len(moved_len),
        .moved_write(moved_write));

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task summarize;
        if (bad_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    task chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk1

    task chk4(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk4

    task chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    // instruction length per timing class
    function int model_len(input int cls, input bit intr, input int waits);
        case (cls)
            0, 9: return 1;
            1, 2, 7, 8, 10: return 2;
            3, 4, 11, 12, 13, 14: return 3;
            5, 15, 16: return 4;
            6: return 4 + waits;
            17: return intr ? 3 : 4;
            default: return 1;
        endcase
    endfunction : model_len

    // ------------------------------------------------------------
    // drivers, entered and left at a falling edge
    // ------------------------------------------------------------
    task sfr_access(input logic [7:0] a, input logic [7:0] d, input logic wr);
        logic hit;
        logic [7:0] exp_d;
        hit = (a === WAIT_ADDR);
        exp_d = (!wr && hit) ? 8'(model_wait) : 8'h00;
        if (wr && hit) model_wait = int'(d) % 8;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_write = wr;
        sfr_read = !wr;
        @(negedge clock);
        sfr_write = 1'b0;
        sfr_read = 1'b0;
        chk8(sfr_rdata, exp_d);
        chk1(sfr_hit, hit);
        // read data and hit stand for one cycle only
        @(negedge clock);
        chk8(sfr_rdata, 8'h00);
        chk1(sfr_hit, 1'b0);
    endtask : sfr_access

    // offer one instruction back to back; poke rewrites the wait count mid-move
    task issue(input int cls, input bit intr, input bit wr, input bit poke);
        int exp;
        int k;
        instr_valid = 1'b1;
        instr_class = instr_class_t'(cls[4:0]);
        from_interrupt = intr;
        instr_write = wr;
        k = 0;
        while (instr_ready !== 1'b1) begin
            @(negedge clock);
            k++;
            if (k > 20) begin
                bad_count++;
                summarize();
            end
        end
        exp = model_len(cls, intr, model_wait);
        len_q.push_back(exp);
        @(posedge clock);
        #1;
        chk1(ale, 1'b1);
        @(negedge clock);
        chk1(first_cycle, 1'b1);
        chk4(instr_cycles, 4'(exp));
        k = 1;
        forever begin
            chk1(ext_access, cls == 6);
            chk1(ext_write, cls == 6 && wr);
            chk1(code_fetch_n, 1'b1);
            chk1(timer_tick, 1'b1);
            if (poke && k == 1) begin
                sfr_addr = WAIT_ADDR;
                sfr_wdata = 8'h06;
                sfr_write = 1'b1;
                model_wait = 6;
            end
            if (instr_ready === 1'b1) break;
            @(posedge clock);
            #1;
            chk1(ale, 1'b0);
            @(negedge clock);
            sfr_write = 1'b0;
            chk1(first_cycle, 1'b0);
            k++;
            if (k > 20) begin
                bad_count++;
                summarize();
            end
        end
        chk4(4'(k), 4'(len_q.pop_front()));
    endtask : issue

    task idle;
        instr_valid = 1'b0;
        @(negedge clock);
        chk1(ext_access, 1'b0);
    endtask : idle

    // ------------------------------------------------------------
    // clock and second-half check of the latch enable
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(negedge clock) begin
        #2;
        chk1(ale, 1'b0);
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        instr_valid = 1'b0;
        instr_class = CLS_ACC_OP;
        from_interrupt = 1'b0;
        instr_write = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_write = 1'b0;
        sfr_read = 1'b0;
        repeat (5) @(negedge clock);
        chk1(instr_ready, 1'b1);
        chk4(instr_cycles, 4'h0);
        chk1(timer_tick, 1'b0);
        chk1(code_fetch_n, 1'b1);
        reset = 1'b0;
        @(negedge clock);
        chk1(timer_tick, 1'b1);
        sfr_access(WAIT_ADDR, 8'h00, 1'b0);
        // every timing class, back to back
        for (int c = 0; c < 18; c++) issue(c, 1'b0, c[0], 1'b0);
        issue(17, 1'b1, 1'b0, 1'b0);
        idle();
        // every wait count, upper bits dropped
        for (int w = 0; w < 8; w++) begin
            sfr_access(WAIT_ADDR, 8'(w) | 8'hf8, 1'b1);
            sfr_access(WAIT_ADDR, 8'h00, 1'b0);
            issue(6, 1'b0, w[0], 1'b0);
            idle();
            chk4(moved_len, 4'(4 + w));
            chk1(moved_write, w[0]);
        end
        // off-map register
        sfr_access(8'h9e, 8'h55, 1'b1);
        sfr_access(8'h9e, 8'h00, 1'b0);
        // wait count rewritten during a move
        sfr_access(WAIT_ADDR, 8'h02, 1'b1);
        issue(6, 1'b0, 1'b1, 1'b1);
        issue(6, 1'b0, 1'b0, 1'b0);
        idle();
        // random classes, flags and wait counts
        repeat (60) begin
            r = $random(seed);
            issue(r & 31, r[5], r[6], 1'b0);
            if (r[8:7] == 2'b00) begin
                idle();
                sfr_access(WAIT_ADDR, r[16:9], 1'b1);
            end
        end
        idle();
        summarize();
    end
endmodule : test_single_cycle_core_timing
